// ---- include/esf_pkg.sv ----
// package: register map, fields and carriers for the event status flags
// Operation
// [R01] The event summary register holds the data overrun flag at bit 6, the buffer event flag at bit 5 and the threshold flag at bit 4.
// [R02] The data overrun flag sets when a new result set latches while the previous set is still unread.
// [R03] The data overrun flag does not set if any axis result register was read before the new set came.
// [R04] Reading the event summary register clears the data overrun flag.
// [R05] While the buffer mode field is above 00b the data overrun flag is held at zero.
// [R06] The buffer event flag is 1 while the watermark, buffer overrun or gating error flag is active.
// [R07] Watermark and buffer overrun show in the buffer state register, gating error in the system state register.
// [R08] The buffer event flag can be active only while the buffer mode field is above 00b.
// [R09] In triggered mode the watermark takes no part in the buffer event flag or its interrupt.
// [R10] In triggered mode the watermark flag itself still asserts once the buffer has been triggered.
// [R11] A host that must know the trigger moment uses the change detector or attitude interrupts instead.
// [R12] A full buffer sets the buffer event flag and raises whichever interrupt line is routed for it.
// [R13] The threshold flag mirrors the outside limits active bit of the first change detect source register.
// [R14] With the latch enable at 1 the threshold flag clears only on a read of the first source register.
// [R15] With the latch enable at 0 the threshold flag clears by itself once the condition ends.
// [R16] A flag set and a clearing read in the same cycle leave the flag set.
package esf_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] ESF_OFS_EVENT_SUMMARY = 8'h00;
  localparam logic [7:0] ESF_OFS_BUF_SETUP = 8'h04;
  localparam logic [7:0] ESF_OFS_BUF_STATE = 8'h08;
  localparam logic [7:0] ESF_OFS_SYS_STATE = 8'h0c;
  localparam logic [7:0] ESF_OFS_CD_SRC1 = 8'h10;
  localparam logic [7:0] ESF_OFS_CD_SETUP1 = 8'h14;
  localparam logic [7:0] ESF_OFS_IRQ_ROUTE = 8'h18;

  // field positions
  localparam int ESF_BIT_OVF = 6;
  localparam int ESF_BIT_BUF = 5;
  localparam int ESF_BIT_OT = 4;
  localparam int ESF_POS_BUF_MODE = 0;
  localparam int ESF_BIT_WMRK = 7;
  localparam int ESF_BIT_BUFFER_OVERRUN_FLAG = 6;
  localparam int ESF_BIT_GATE_ERR = 1;
  localparam int ESF_BIT_OT_ACTIVE = 7;
  localparam int ESF_BIT_OT_LATCH = 0;
  localparam int ESF_BIT_RT_BUF_A = 0;
  localparam int ESF_BIT_RT_BUF_B = 1;
  localparam int ESF_BIT_RT_OVF_A = 2;
  localparam int ESF_BIT_RT_OVF_B = 3;
  localparam int ESF_BIT_RT_OT_A = 4;
  localparam int ESF_BIT_RT_OT_B = 5;

  // reset values of writable registers
  localparam logic [7:0] ESF_RST_BUF_SETUP = 8'h00;
  localparam logic [7:0] ESF_RST_CD_SETUP1 = 8'h00;
  localparam logic [7:0] ESF_RST_IRQ_ROUTE = 8'h00;

  // buffer operating modes, off must stay the zero code
  typedef enum logic [1:0] {
    ESF_MODE_OFF,
    ESF_MODE_STREAM,
    ESF_MODE_STOP,
    ESF_MODE_TRIG
  } esf_buf_mode_t;

  // live status from the buffer logic
  typedef struct packed {
    logic watermark;
    logic overrun;
    logic gate_err;
    logic full;
    logic triggered;
  } esf_buf_status_t;

  // full byte address match, used by write and side effect decodes
  function automatic logic esf_hit(input logic [7:0] addr,
                                   input logic [7:0] ofs);
    esf_hit = (addr == ofs);
  endfunction : esf_hit

endpackage : esf_pkg

// ---- design/esf_ot_latch.sv ----
// threshold exceedance flag with optional latching
`timescale 1ns/1ps
module esf_ot_latch
  import esf_pkg::*;
(
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic ot_cond, // outside limits condition, level
  input wire logic latch_en, // outside limits latch enable
  input wire logic src1_clr, // read of source register 1 shown a 1
  output logic threshold_exceed_flag // flag, registered
);

  logic flag_reg;
  logic flag_next;

  // latched mode holds until read, else the flag just follows the condition
  always_comb begin
    if (latch_en) begin
      flag_next = ot_cond | (flag_reg & ~src1_clr); // see [R14] see [R16]
    end else begin
      flag_next = ot_cond; // see [R15]
    end
  end

  // flag storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next; // see [R13]
    end
  end

  assign threshold_exceed_flag = flag_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_ot_mirror;
    @(posedge pclk) disable iff (!presetn)
      ot_cond |=> threshold_exceed_flag;
  endproperty
  a_ot_mirror: assert property (p_ot_mirror) // see [R13]
    else $error("threshold flag missed the condition");

  property p_ot_latched;
    @(posedge pclk) disable iff (!presetn)
      latch_en && threshold_exceed_flag && !src1_clr |=> threshold_exceed_flag;
  endproperty
  a_ot_latched: assert property (p_ot_latched) // see [R14]
    else $error("latched threshold flag dropped without a read");

  property p_ot_auto;
    @(posedge pclk) disable iff (!presetn)
      !latch_en && !ot_cond |=> !threshold_exceed_flag;
  endproperty
  a_ot_auto: assert property (p_ot_auto) // see [R15]
    else $error("unlatched threshold flag did not clear");

  c_ot_read_clear: cover property (@(posedge pclk) disable iff (!presetn)
    latch_en && threshold_exceed_flag && src1_clr && !ot_cond
    ##1 !threshold_exceed_flag);

endmodule : esf_ot_latch

// ---- design/esf_event_flags.sv ----
// event summary flags: data overrun, buffer event, threshold exceedance
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module esf_event_flags
  import esf_pkg::*;
(
  input wire logic pclk, // bus clock, 20 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction, high is write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data, registered
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic new_sample, // pulse: result set latched
  input wire logic axis_read, // pulse: an axis result register read
  input wire esf_buf_status_t buf_in, // live buffer status
  input wire logic ot_cond, // outside limits condition, level
  output logic irq_line_a, // interrupt line a, active high
  output logic irq_line_b // interrupt line b, active high
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0] buf_setup_reg;
  logic [7:0] cd_setup1_reg;
  logic [7:0] irq_route_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic pending_reg;
  logic ovf_reg;
  logic ovf_next;
  logic buf_flag_reg;
  logic buf_flag_next;
  logic wmrk_flag_reg;
  logic wmrk_flag_next;
  logic irq_a_reg;
  logic irq_b_reg;
  logic ot_flag;
  logic [7:0] read_word;
  logic mapped;
  logic apb_setup;
  logic apb_access;
  logic wr_access;
  logic sum_rd_clr;
  logic src1_clr;
  logic ovf_set;
  logic buf_on;
  esf_buf_mode_t buf_mode;

  ////////////////////////////////////////////////////////////////////////////
  // apb phases

  // zero wait states: read data is fetched in the setup cycle
  assign apb_setup = psel & ~penable;
  assign apb_access = psel & penable;
  assign wr_access = apb_access & pwrite & mapped;
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

  // buffer mode decode
  assign buf_mode = esf_buf_mode_t'(buf_setup_reg[ESF_POS_BUF_MODE +: 2]);
  assign buf_on = (buf_mode != ESF_MODE_OFF);

  // read mux; low address bits must be zero or the access is unmapped
  always_comb begin
    read_word = 8'h00;
    mapped = 1'b1;
    case (paddr)
      ESF_OFS_EVENT_SUMMARY: begin
        read_word[ESF_BIT_OVF] = ovf_reg; // see [R01]
        read_word[ESF_BIT_BUF] = buf_flag_reg; // see [R01]
        read_word[ESF_BIT_OT] = ot_flag; // see [R01]
      end
      ESF_OFS_BUF_SETUP: begin
        read_word = buf_setup_reg;
      end
      ESF_OFS_BUF_STATE: begin
        read_word[ESF_BIT_WMRK] = wmrk_flag_reg; // see [R07]
        read_word[ESF_BIT_BUFFER_OVERRUN_FLAG] = buf_in.overrun; // see [R07]
      end
      ESF_OFS_SYS_STATE: begin
        read_word[ESF_BIT_GATE_ERR] = buf_in.gate_err; // see [R07]
      end
      ESF_OFS_CD_SRC1: begin
        read_word[ESF_BIT_OT_ACTIVE] = ot_flag;
      end
      ESF_OFS_CD_SETUP1: begin
        read_word = cd_setup1_reg;
      end
      ESF_OFS_IRQ_ROUTE: begin
        read_word = irq_route_reg;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // read data and error captured in setup, held through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (apb_setup) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : {24'h00_0000, read_word};
      pslverr_reg <= ~mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // writable registers

  // writes land on the access edge; writes to read-only words are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_setup_reg <= ESF_RST_BUF_SETUP;
      cd_setup1_reg <= ESF_RST_CD_SETUP1;
      irq_route_reg <= ESF_RST_IRQ_ROUTE;
    end else if (wr_access) begin
      if (esf_hit(paddr, ESF_OFS_BUF_SETUP)) begin
        buf_setup_reg <= pwdata[7:0];
      end
      if (esf_hit(paddr, ESF_OFS_CD_SETUP1)) begin
        cd_setup1_reg <= pwdata[7:0];
      end
      if (esf_hit(paddr, ESF_OFS_IRQ_ROUTE)) begin
        irq_route_reg <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read side effects

  // clear only a bit the host actually saw as 1, so a set after the
  // setup-cycle fetch is not wiped by the access edge
  assign sum_rd_clr = apb_access & ~pwrite &
                      esf_hit(paddr, ESF_OFS_EVENT_SUMMARY);
  assign src1_clr = apb_access & ~pwrite & esf_hit(paddr, ESF_OFS_CD_SRC1) &
                    prdata_reg[ESF_BIT_OT_ACTIVE];

  ////////////////////////////////////////////////////////////////////////////
  // data overrun flag

  // unread marker: a new set arms it, an axis read without a new set in the same cycle disarms it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_reg <= 1'b0;
    end else begin
      pending_reg <= new_sample | (pending_reg & ~axis_read); // see [R03]
    end
  end

  // a read in the same cycle as a new set counts as a read of the old set
  assign ovf_set = new_sample & pending_reg & ~axis_read & ~buf_on; // see [R02]

  always_comb begin
    if (buf_on) begin
      ovf_next = 1'b0; // see [R05]
    end else begin
      ovf_next = ovf_set |
                 (ovf_reg & ~(sum_rd_clr & prdata_reg[ESF_BIT_OVF])); // see [R04] see [R16]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_reg <= 1'b0;
    end else begin
      ovf_reg <= ovf_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer event and watermark flags

  // in triggered mode the watermark waits for the trigger and stays out of
  // the summary; the host cannot learn the trigger moment from it
  always_comb begin
    wmrk_flag_next = buf_in.watermark &
                     ((buf_mode != ESF_MODE_TRIG) | buf_in.triggered); // see [R10]
    buf_flag_next = buf_on &
                    ((wmrk_flag_next & (buf_mode != ESF_MODE_TRIG)) |
                     buf_in.overrun | buf_in.gate_err |
                     buf_in.full); // see [R06] see [R08] see [R09] see [R12]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_flag_reg <= 1'b0;
      wmrk_flag_reg <= 1'b0;
    end else begin
      buf_flag_reg <= buf_flag_next;
      wmrk_flag_reg <= wmrk_flag_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // threshold exceedance flag

  esf_ot_latch u_ot_latch (
    .pclk (pclk),
    .presetn (presetn),
    .ot_cond (ot_cond),
    .latch_en (cd_setup1_reg[ESF_BIT_OT_LATCH]),
    .src1_clr (src1_clr),
    .threshold_exceed_flag (ot_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // interrupt lines

  // each flag is routed to line a, line b, both or neither
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_a_reg <= 1'b0;
      irq_b_reg <= 1'b0;
    end else begin
      irq_a_reg <= (irq_route_reg[ESF_BIT_RT_BUF_A] & buf_flag_reg) |
                   (irq_route_reg[ESF_BIT_RT_OVF_A] & ovf_reg) |
                   (irq_route_reg[ESF_BIT_RT_OT_A] & ot_flag); // see [R12]
      irq_b_reg <= (irq_route_reg[ESF_BIT_RT_BUF_B] & buf_flag_reg) |
                   (irq_route_reg[ESF_BIT_RT_OVF_B] & ovf_reg) |
                   (irq_route_reg[ESF_BIT_RT_OT_B] & ot_flag); // see [R12]
    end
  end

  assign irq_line_a = irq_a_reg;
  assign irq_line_b = irq_b_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_summary_map;
    @(posedge pclk) disable iff (!presetn)
      apb_setup && !pwrite && esf_hit(paddr, ESF_OFS_EVENT_SUMMARY)
      |=> prdata[ESF_BIT_OVF] == $past(ovf_reg) &&
          prdata[ESF_BIT_BUF] == $past(buf_flag_reg) &&
          prdata[ESF_BIT_OT] == $past(ot_flag);
  endproperty
  a_summary_map: assert property (p_summary_map) // see [R01]
    else $error("summary bits not at their positions");

  property p_ovf_set;
    @(posedge pclk) disable iff (!presetn)
      new_sample && pending_reg && !axis_read && !buf_on |=> ovf_reg;
  endproperty
  a_ovf_set: assert property (p_ovf_set) // see [R02]
    else $error("overrun flag did not set on unread set");

  property p_ovf_no_set;
    @(posedge pclk) disable iff (!presetn)
      axis_read && !new_sample && !ovf_reg
      ##1 !new_sample ##1 new_sample && !axis_read |=> !ovf_reg;
  endproperty
  a_ovf_no_set: assert property (p_ovf_no_set) // see [R03]
    else $error("overrun flag set although an axis was read");

  property p_ovf_clear;
    @(posedge pclk) disable iff (!presetn)
      sum_rd_clr && prdata_reg[ESF_BIT_OVF] && !ovf_set |=> !ovf_reg;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) // see [R04]
    else $error("summary read did not clear overrun flag");

  property p_ovf_forced;
    @(posedge pclk) disable iff (!presetn)
      buf_on |=> !ovf_reg;
  endproperty
  a_ovf_forced: assert property (p_ovf_forced) // see [R05]
    else $error("overrun flag set while buffer enabled");

  property p_buf_any;
    @(posedge pclk) disable iff (!presetn)
      buf_on && (buf_in.overrun || buf_in.gate_err) |=> buf_flag_reg;
  endproperty
  a_buf_any: assert property (p_buf_any) // see [R06]
    else $error("buffer event flag missed an active source");

  property p_buf_state;
    @(posedge pclk) disable iff (!presetn)
      apb_setup && !pwrite && esf_hit(paddr, ESF_OFS_BUF_STATE)
      |=> prdata[ESF_BIT_WMRK] == $past(wmrk_flag_reg);
  endproperty
  a_buf_state: assert property (p_buf_state) // see [R07]
    else $error("buffer state register shows wrong watermark");

  property p_buf_off;
    @(posedge pclk) disable iff (!presetn)
      !buf_on |=> !buf_flag_reg;
  endproperty
  a_buf_off: assert property (p_buf_off) // see [R08]
    else $error("buffer event flag active with buffer off");

  property p_trig_no_wm;
    @(posedge pclk) disable iff (!presetn)
      buf_mode == ESF_MODE_TRIG && !buf_in.overrun && !buf_in.gate_err &&
      !buf_in.full |=> !buf_flag_reg;
  endproperty
  a_trig_no_wm: assert property (p_trig_no_wm) // see [R09]
    else $error("watermark raised buffer event in triggered mode");

  property p_trig_wm;
    @(posedge pclk) disable iff (!presetn)
      buf_mode == ESF_MODE_TRIG && buf_in.watermark && buf_in.triggered
      |=> wmrk_flag_reg;
  endproperty
  a_trig_wm: assert property (p_trig_wm) // see [R10]
    else $error("watermark not asserted after trigger");

  property p_full_irq;
    @(posedge pclk) disable iff (!presetn)
      buf_on && buf_in.full && irq_route_reg[ESF_BIT_RT_BUF_A]
      ##1 irq_route_reg[ESF_BIT_RT_BUF_A] |=> irq_line_a;
  endproperty
  a_full_irq: assert property (p_full_irq) // see [R12]
    else $error("full buffer did not raise line a");

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
      ovf_set && sum_rd_clr |=> ovf_reg;
  endproperty
  a_set_wins: assert property (p_set_wins) // see [R16]
    else $error("overrun event lost to a clearing read");

  c_ovf_set: cover property (@(posedge pclk) disable iff (!presetn)
    ovf_set ##1 ovf_reg);
  c_set_and_clear: cover property (@(posedge pclk) disable iff (!presetn)
    ovf_set && sum_rd_clr && prdata_reg[ESF_BIT_OVF]);
  c_full_irq: cover property (@(posedge pclk) disable iff (!presetn)
    buf_in.full && buf_on ##2 irq_line_a);
  c_trig_wm: cover property (@(posedge pclk) disable iff (!presetn)
    buf_mode == ESF_MODE_TRIG && wmrk_flag_reg && !buf_flag_reg);

endmodule : esf_event_flags

// ---- testbench/esf_host_model.sv ----
// apb host model that reaches the event summary block
`timescale 1ns/1ps
module esf_host_model (
  input wire logic pclk, // bus clock
  output logic psel, // select
  output logic penable, // enable
  output logic pwrite, // direction, high is write
  output logic [7:0] paddr, // byte address
  output logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr // error answer
);
  // bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  //////////////////////////////////////////////////////////////////////
  // one transfer; no latency is assumed, the bench watchdog ends a hang
  // the trigger moment is not polled through the watermark: a host that
  // needs it watches the detector flags instead
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    // released address and data lines show the inverse so stale values are never reused
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : esf_host_model

// ---- testbench/testbench.sv ----
// self-checking bench for the event summary flags
`timescale 1ns/1ps
module testbench
  import esf_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic new_sample, axis_read, ot_cond, irq_line_a, irq_line_b;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  esf_buf_status_t buf_in;
  int error_cnt, samples_checked;

  esf_event_flags u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .new_sample(new_sample), .axis_read(axis_read), .buf_in(buf_in),
    .ot_cond(ot_cond), .irq_line_a(irq_line_a), .irq_line_b(irq_line_b));

  esf_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // 20 MHz clock
  always #25 pclk = ~pclk;

  //////////////////////////////////////////////////////////////////////
  // comparison, verdict and small helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen,
               exp);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // read a register and compare data, error answer must be low
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    u_host.xfer(1'b0, a, 32'h0, rd, err);
    check(rd, exp);
    check({31'h0, err}, 32'h0);
  endtask : rd_chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    u_host.xfer(1'b1, a, d, rd, err);
  endtask : wr

  // one-cycle pulses on the sample side
  task automatic pulses(input logic s, input logic r);
    @(posedge pclk);
    new_sample <= s;
    axis_read <= r;
    @(posedge pclk);
    new_sample <= 1'b0;
    axis_read <= 1'b0;
  endtask : pulses

  //////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    logic [31:0] rd;
    logic err;
    rd_chk(ESF_OFS_EVENT_SUMMARY, 32'h0);
    rd_chk(ESF_OFS_IRQ_ROUTE, 32'h0);
    wr(ESF_OFS_EVENT_SUMMARY, 32'hff); // read-only place
    rd_chk(ESF_OFS_EVENT_SUMMARY, 32'h0);
    u_host.xfer(1'b0, 8'h1c, 32'h0, rd, err);
    check({31'h0, err}, 32'h1);
    u_host.xfer(1'b0, 8'h01, 32'h0, rd, err);
    check({31'h0, err}, 32'h1);
  endtask : t_reset

  // two results with no axis read between them
  task automatic t_overrun;
    wr(ESF_OFS_IRQ_ROUTE, 32'h04);
    pulses(1'b1, 1'b0);
    pulses(1'b1, 1'b0);
    cyc(3);
    check({31'h0, irq_line_a}, 32'h1);
    rd_chk(ESF_OFS_EVENT_SUMMARY, 32'h40);
    rd_chk(ESF_OFS_EVENT_SUMMARY, 32'h0);
    cyc(2);
    check({31'h0, irq_line_a}, 32'h0);
    // the last set is still unread: disarm first, then set, read, set
    pulses(1'b0, 1'b1);
    pulses(1'b1, 1'b0);
    pulses(1'b0, 1'b1);
    pulses(1'b1, 1'b0);
    cyc(2);
    rd_chk(ESF_OFS_EVENT_SUMMARY, 32'h0);
    pulses(1'b0, 1'b1);
  endtask : t_overrun

  // buffer on holds the overrun flag low, even with new overruns
  task automatic t_mode_gate;
    pulses(1'b1, 1'b0);
    pulses(1'b1, 1'b0);
    // stop mode here, stream mode is used by the buffer scenario
    wr(ESF_OFS_BUF_SETUP, 32'h2);
    cyc(2);
    rd_chk(ESF_OFS_EVENT_SUMMARY, 32'h0);
    pulses(1'b1, 1'b0);
    cyc(2);
    rd_chk(ESF_OFS_EVENT_SUMMARY, 32'h0);
    wr(ESF_OFS_BUF_SETUP, 32'h0);
    pulses(1'b0, 1'b1);
    rd_chk(ESF_OFS_EVENT_SUMMARY, 32'h0);
  endtask : t_mode_gate

  // each buffer source alone, then the triggered-mode watermark
  task automatic t_buffer;
    // buffer event routed to both lines
    wr(ESF_OFS_IRQ_ROUTE, 32'h03);
    @(posedge pclk);
    buf_in <= 5'h04;
    cyc(3);
    rd_chk(ESF_OFS_EVENT_SUMMARY, 32'h0);
    wr(ESF_OFS_BUF_SETUP, 32'h1);
    for (int i = 1; i <= 4; i++) begin
      @(posedge pclk);
      buf_in <= 5'(1 << i);
      cyc(3);
      rd_chk(ESF_OFS_EVENT_SUMMARY, 32'h20);
      check({31'h0, irq_line_b}, 32'h1);
      check({31'h0, irq_line_a}, 32'h1);
      rd_chk(ESF_OFS_BUF_STATE, {24'h0, i == 4, i == 3, 6'h0});
      rd_chk(ESF_OFS_SYS_STATE, (i == 2) ? 32'h2 : 32'h0);
    end
    wr(ESF_OFS_BUF_SETUP, 32'h3);
    @(posedge pclk);
    buf_in <= 5'h11;
    cyc(3);
    rd_chk(ESF_OFS_EVENT_SUMMARY, 32'h0);
    check({31'h0, irq_line_b}, 32'h0);
    rd_chk(ESF_OFS_BUF_STATE, 32'h80);
    @(posedge pclk);
    buf_in <= 5'h00;
    wr(ESF_OFS_BUF_SETUP, 32'h0);
  endtask : t_buffer

  // threshold flag, following and latched
  task automatic t_threshold;
    wr(ESF_OFS_IRQ_ROUTE, 32'h10);
    @(posedge pclk);
    ot_cond <= 1'b1;
    cyc(3);
    rd_chk(ESF_OFS_EVENT_SUMMARY, 32'h10);
    check({31'h0, irq_line_a}, 32'h1);
    @(posedge pclk);
    ot_cond <= 1'b0;
    cyc(3);
    rd_chk(ESF_OFS_EVENT_SUMMARY, 32'h0);
    wr(ESF_OFS_CD_SETUP1, 32'h1);
    @(posedge pclk);
    ot_cond <= 1'b1;
    cyc(2);
    ot_cond <= 1'b0;
    cyc(3);
    rd_chk(ESF_OFS_EVENT_SUMMARY, 32'h10);
    rd_chk(ESF_OFS_EVENT_SUMMARY, 32'h10);
    rd_chk(ESF_OFS_CD_SRC1, 32'h80);
    rd_chk(ESF_OFS_EVENT_SUMMARY, 32'h0);
    wr(ESF_OFS_CD_SETUP1, 32'h0);
  endtask : t_threshold

  // a new overrun lands on the clearing access edge and must survive
  task automatic t_race;
    logic [31:0] rd;
    logic err;
    pulses(1'b1, 1'b0);
    pulses(1'b1, 1'b0);
    cyc(2);
    fork
      u_host.xfer(1'b0, ESF_OFS_EVENT_SUMMARY, 32'h0, rd, err);
      begin
        cyc(2);
        new_sample <= 1'b1;
        @(posedge pclk);
        new_sample <= 1'b0;
      end
    join
    check(rd, 32'h40);
    rd_chk(ESF_OFS_EVENT_SUMMARY, 32'h40);
    rd_chk(ESF_OFS_EVENT_SUMMARY, 32'h0);
    pulses(1'b0, 1'b1);
  endtask : t_race

  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    new_sample = 1'b0;
    axis_read = 1'b0;
    ot_cond = 1'b0;
    buf_in = '0;
    error_cnt = 0;
    samples_checked = 0;
    cyc(4);
    presetn <= 1'b1;
    t_reset;
    t_overrun;
    t_mode_gate;
    t_buffer;
    t_threshold;
    t_race;
    complete_run;
  end

  // watchdog, well past the few hundred cycles the scenarios take
  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    complete_run;
  end
endmodule : testbench
